/* File: core/eil_pkg.sv */
// Purpose: constants and types shared by the external interrupt latch
// Assumes: wishbone classic slave, 32-bit data, 8-bit registers in low bits
// Notes: offsets are byte addresses of aligned words
//
// Overview of operation
// - with break-clear enable set, software acknowledge in break state clears latch
// - a latch cleared during break stays cleared once break ends
// - with break-clear enable clear, acknowledge in break state leaves latch alone
// - pending flag is read-only, one while request pending, else zero
// - writing one to write-only acknowledge bit clears latch, break limits apply
// - acknowledge bit always reads zero and is cleared by reset
// - mask bit one blocks request to cpu; reset clears mask
// - sensitivity one: falling edge and low level; zero: falling edge only
// - falling edge on active-low pin sets latch in either mode
// - edge-only mode: vector fetch or software acknowledge clears latch at once
// - edge-and-level mode: clear needs acknowledge and pin high, any order
// - unmasked serviced request takes vector from the two fixed vector addresses
package eil_pkg;
    localparam logic [7:0] EIL_OFS_STATUS = 8'h00;
    localparam logic [7:0] EIL_OFS_BREAK = 8'h04;
    localparam logic [7:0] EIL_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] EIL_OFS_IRQ_MASK = 8'h0C;
    // status/control bit positions
    localparam int EIL_BIT_MODE = 0;
    localparam int EIL_BIT_MASK = 1;
    localparam int EIL_BIT_ACK = 2;
    localparam int EIL_BIT_PEND = 3;
    localparam int EIL_BIT_BREAK_CLEAR_ENABLE = 0;
    localparam logic [7:0] EIL_RST_CTRL = 8'h00;
    localparam logic EIL_RST_BREAK_CLEAR_ENABLE = 1'b0;
    // event bits: 0 latch set, 1 latch cleared
    localparam int EIL_EVT_W = 2;
    localparam logic [15:0] EIL_VEC_HI = 16'hFFFA;
    localparam logic [15:0] EIL_VEC_LO = 16'hFFFB;
    localparam logic [31:0] EIL_RD_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } eil_wb_req_s;

    typedef struct packed {
        logic mode;
        logic mask;
        logic break_clear_enable;
    } eil_ctrl_s;
endpackage

/* File: core/eil_pin_sync.sv */
// Purpose: two-flop synchroniser and falling edge detector for the pin
// Assumes: pin idles high
// Notes: first flop feeds only the second
`timescale 1ns/100ps
module eil_pin_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // pin side
    input wire logic irq_pin_n,
    // detected
    output logic pin_level,
    output logic pin_fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= irq_pin_n;
            sync <= meta;
            prev <= sync;
        end
    end

    assign pin_level = sync;
    assign pin_fall = prev & ~sync;
endmodule

/* File: core/eil_wb_slave.sv */
// Purpose: classic wishbone slave front end, one-cycle ack
// Assumes: master holds request until ack
// Notes: ack drops the cycle after it is given
`timescale 1ns/100ps
module eil_wb_slave (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // bus
    input wire eil_pkg::eil_wb_req_s req,
    output logic ack_o,
    // access strobes
    output logic wr_stb,
    output logic rd_stb
);
    logic ack;
    wire access = req.cyc & req.stb & ~ack;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= access;
        end
    end

    assign ack_o = ack;
    // writes take effect at the acked edge
    assign wr_stb = ack & req.we & req.sel[0];
    assign rd_stb = ack & ~req.we;
endmodule

/* File: core/eil_top.sv */
// Purpose: external interrupt request latch with status/control register
// Assumes: cpu gives vector fetch pulse and break state level
// Notes: registers on classic wishbone, answer in one wait cycle
`timescale 1ns/100ps
module eil_top (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // external pin
    input wire logic irq_pin_n,
    // cpu side
    input wire logic vec_fetch,
    input wire logic break_state,
    output logic cpu_irq_req,
    output logic [15:0] vec_addr_hi,
    output logic [15:0] vec_addr_lo,
    // summary interrupt
    output logic irq
);
    eil_pkg::eil_wb_req_s req;
    eil_pkg::eil_ctrl_s ctrl;
    logic latch;
    logic ack_pend;
    logic [eil_pkg::EIL_EVT_W-1:0] evt_stat;
    logic [eil_pkg::EIL_EVT_W-1:0] evt_mask;
    logic [31:0] rd_data;
    logic wr_stb;
    logic pin_level;
    logic pin_fall;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    eil_wb_slave u_bus (
        .mclk(mclk),
        .arst_n(arst_n),
        .req(req),
        .ack_o(wb_ack_o),
        .wr_stb(wr_stb),
        .rd_stb()
    );

    eil_pin_sync u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .irq_pin_n(irq_pin_n),
        .pin_level(pin_level),
        .pin_fall(pin_fall)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire sel_status = req.adr == eil_pkg::EIL_OFS_STATUS;
    wire sel_break = req.adr == eil_pkg::EIL_OFS_BREAK;
    wire sel_istat = req.adr == eil_pkg::EIL_OFS_IRQ_STAT;
    wire sel_request_mask = req.adr == eil_pkg::EIL_OFS_IRQ_MASK;
    wire wr_status = wr_stb & sel_status;
    wire sw_ack = wr_status & req.dat[eil_pkg::EIL_BIT_ACK];
    wire sw_ack_ok = sw_ack & (~break_state | ctrl.break_clear_enable);
    wire any_ack = sw_ack_ok | vec_fetch;
    // level re-arm only in edge-and-level mode
    wire level_hold = ctrl.mode & ~pin_level;
    wire clr_now = ctrl.mode ? ((any_ack | ack_pend) & pin_level) : any_ack;
    // edge sets regardless of mode, set wins
    wire next_latch = pin_fall | level_hold | (latch & ~clr_now);
    wire evt_set = next_latch & ~latch;
    wire evt_clr = latch & ~next_latch;
    wire [eil_pkg::EIL_EVT_W-1:0] evt = {evt_clr, evt_set};

    // ------------------------------------------------------------
    // latch and control
    // ------------------------------------------------------------
    // cleared latch simply stays cleared
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            latch <= 1'b0;
            ack_pend <= 1'b0;
        end else begin
            latch <= next_latch;
            ack_pend <= ctrl.mode & latch & ~pin_level & (any_ack | ack_pend);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl.mode <= eil_pkg::EIL_RST_CTRL[eil_pkg::EIL_BIT_MODE];
            ctrl.mask <= eil_pkg::EIL_RST_CTRL[eil_pkg::EIL_BIT_MASK];
            ctrl.break_clear_enable <= eil_pkg::EIL_RST_BREAK_CLEAR_ENABLE;
        end else begin
            if (wr_status) begin
                ctrl.mode <= req.dat[eil_pkg::EIL_BIT_MODE];
                ctrl.mask <= req.dat[eil_pkg::EIL_BIT_MASK];
            end
            if (wr_stb & sel_break) begin
                ctrl.break_clear_enable <= req.dat[eil_pkg::EIL_BIT_BREAK_CLEAR_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------
    // event status (write one to clear) and mask (plain write)
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            evt_stat <= '0;
            evt_mask <= '0;
        end else begin
            // set wins over clear in the same cycle
            evt_stat <= evt | (evt_stat & ~(req.dat[eil_pkg::EIL_EVT_W-1:0]
                        & {eil_pkg::EIL_EVT_W{wr_stb & sel_istat}}));
            if (wr_stb & sel_request_mask) begin
                evt_mask <= req.dat[eil_pkg::EIL_EVT_W-1:0];
            end
        end
    end

    // mask bit one silences its event, reset leaves all events enabled
    assign irq = |(evt_stat & ~evt_mask);

    // ------------------------------------------------------------
    // cpu side
    // ------------------------------------------------------------
    // mask gates request
    assign cpu_irq_req = latch & ~ctrl.mask;
    assign vec_addr_hi = eil_pkg::EIL_VEC_HI;
    assign vec_addr_lo = eil_pkg::EIL_VEC_LO;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // pending readback, ack reads zero
    wire [31:0] rd_status = {28'h0000000, latch, 1'b0, ctrl.mask, ctrl.mode};
    wire [31:0] rd_break = {31'h0, ctrl.break_clear_enable};
    wire [31:0] rd_istat = {30'h0, evt_stat};
    wire [31:0] rd_request_mask = {30'h0, evt_mask};
    assign rd_data = sel_status ? rd_status :
                     sel_break ? rd_break :
                     sel_istat ? rd_istat :
                     sel_request_mask ? rd_request_mask : eil_pkg::EIL_RD_UNMAPPED;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= req.cyc & req.stb & ~req.we ? rd_data : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_ack_in_break;
        sw_ack & break_state & ~ctrl.break_clear_enable & ~pin_fall & ~vec_fetch;
    endsequence

    a_break_protect: assert property (@(posedge mclk) disable iff (!arst_n)
        s_ack_in_break and latch |=> latch)
        else $error("latch cleared in break while protected");
    a_break_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        sw_ack & break_state & ctrl.break_clear_enable & ~ctrl.mode & ~pin_fall |=> !latch)
        else $error("enabled break clear failed");
    a_stays_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        !latch & ~pin_fall & ~level_hold & $fell(break_state) |=> !latch)
        else $error("latch restored at break exit");
    a_edge_sets: assert property (@(posedge mclk) disable iff (!arst_n)
        pin_fall |=> latch)
        else $error("falling edge did not set latch");
    a_edge_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        !ctrl.mode & vec_fetch & ~pin_fall |=> !latch)
        else $error("edge mode clear failed");
    a_level_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        ctrl.mode & !pin_level |=> latch)
        else $error("latch cleared while pin low");
    a_mask_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        cpu_irq_req == (latch & !ctrl.mask))
        else $error("mask gating wrong");
    a_pend_read: assert property (@(posedge mclk) disable iff (!arst_n)
        wb_ack_o & !req.we & sel_status |-> wb_dat_o[eil_pkg::EIL_BIT_PEND] == $past(latch)
        && !wb_dat_o[eil_pkg::EIL_BIT_ACK])
        else $error("status readback wrong");
    a_vector_pair: assert property (@(posedge mclk) disable iff (!arst_n)
        vec_addr_lo == vec_addr_hi + 16'h0001)
        else $error("vector pair wrong");
    a_sync_once: assert property (@(posedge mclk) disable iff (!arst_n)
        pin_fall |=> !pin_fall)
        else $error("edge detected twice");
endmodule

/* File: dv/eil_pin_src.sv */
// Purpose: external source driving the active-low interrupt pin
// Assumes: bench asks for low level through pull_low
// Notes: pin has a pull-up, so idle is high
`timescale 1ns/100ps
module eil_pin_src (
    // clock
    input wire logic mclk,
    // control
    input wire logic pull_low,
    // pin
    output logic irq_pin_n
);
    logic drive_low;

    always_ff @(posedge mclk) begin
        drive_low <= pull_low;
    end

    // released pin floats to the pull-up level, also before the first edge
    assign irq_pin_n = (drive_low === 1'b1) ? 1'b0 : 1'b1;
endmodule

/* File: dv/test_external_interrupt_latch.sv */
// Purpose: self-checking bench for the external interrupt latch
// Assumes: one-wait-cycle wishbone answer, mask bit one masks an event
// Notes: pin edges come from the source model
`timescale 1ns/100ps
module test_external_interrupt_latch;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    logic ack, pull_low = 1'b0, pin_n, vf = 1'b0, brk = 1'b0, req, irq;
    logic [15:0] vhi, vlo;
    int mismatches = 0, check_count = 0;
    eil_top dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq_pin_n(pin_n), .vec_fetch(vf),
        .break_state(brk), .cpu_irq_req(req), .vec_addr_hi(vhi),
        .vec_addr_lo(vlo), .irq(irq));
    eil_pin_src src (.mclk(mclk), .pull_low(pull_low), .irq_pin_n(pin_n));
    initial forever #25 mclk = ~mclk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        chk(ack, 1'b1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    // pin edge, then wait past the sync flops
    task automatic pin(input logic low);
        @(posedge mclk);
        pull_low <= low;
        repeat (6) @(posedge mclk);
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h0);
        wb(0, eil_pkg::EIL_OFS_BREAK, 0); chk(q, 32'h0);
        wb(0, 8'h10, 0); chk(q, eil_pkg::EIL_RD_UNMAPPED);
        chk({vhi, vlo}, 32'hFFFA_FFFB);
        $display("reset test done");
    endtask
    task automatic t_edge;
        pin(1); chk(req, 1'b1);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h08);
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h04); pin(1);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h00);
        chk(req, 1'b0);
        pin(0);
        $display("edge test done");
    endtask
    task automatic t_mask;
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h02); pin(1);
        chk(req, 1'b0);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h0A);
        @(posedge mclk); vf <= 1'b1;
        @(posedge mclk); vf <= 1'b0;
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h02);
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h00); pin(0);
        $display("mask test done");
    endtask
    task automatic t_level;
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h01); pin(1);
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h05);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h09);
        pin(0);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h01);
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h00);
        $display("level test done");
    endtask
    task automatic t_break;
        @(posedge mclk); brk <= 1'b1;
        pin(1);
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h04);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h08);
        wb(1, eil_pkg::EIL_OFS_BREAK, 32'h01);
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h04);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h00);
        @(posedge mclk); brk <= 1'b0;
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h00);
        pin(0);
        $display("break test done");
    endtask
    task automatic t_events;
        wb(0, eil_pkg::EIL_OFS_IRQ_STAT, 0); chk(q, 32'h03);
        chk(irq, 1'b1);
        // irq follows the mask write at the acked edge, look once it settles
        wb(1, eil_pkg::EIL_OFS_IRQ_MASK, 32'h03);
        @(negedge mclk); chk(irq, 1'b0);
        wb(1, eil_pkg::EIL_OFS_IRQ_MASK, 32'h00);
        @(negedge mclk); chk(irq, 1'b1);
        wb(1, eil_pkg::EIL_OFS_IRQ_STAT, 32'h03);
        wb(0, eil_pkg::EIL_OFS_IRQ_STAT, 0); chk(q, 32'h00);
        chk(irq, 1'b0);
        $display("event test done");
    endtask
    // reset in mid-run with level mode, mask and a held latch
    task automatic t_rst_mid;
        wb(1, eil_pkg::EIL_OFS_STATUS, 32'h03); pin(1); pin(0);
        chk(req, 1'b0);
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h0B);
        @(posedge mclk); arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk); chk(req, 1'b0);
        @(posedge mclk); arst_n <= 1'b1;
        wb(0, eil_pkg::EIL_OFS_STATUS, 0); chk(q, 32'h00);
        wb(0, eil_pkg::EIL_OFS_BREAK, 0); chk(q, 32'h00);
        $display("mid-run reset test done");
    endtask
    // ----------------------------------------
    // main and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset;
        t_edge;
        t_mask;
        t_level;
        t_break;
        t_events;
        t_rst_mid;
        wrap_up;
    end
    // whole run is a few hundred cycles
    initial begin
        #(5000 * 50);
        mismatches++;
        wrap_up;
    end
endmodule
